// ### bench/bstx_line_model.sv
`timescale 1ns/1ps
module bstx_line_model (
  // Modem levels requested by the bench
  input  wire logic cts_on,
  input  wire logic dcd_on,
  // Serial line
  input  wire logic txd,
  output logic      tx_clk,
  output logic      cts_n,
  output logic      dcd_n,
  // Received bits, newest in the top bit, and count of space bits
  output logic [15:0] line_sr,
  output int          zeros
);
  // The synchronous line clock runs free, as a modem supplies it.
  initial begin
    tx_clk  = 1'b0;
    line_sr = 16'h0000;
    zeros   = 0;
  end
  always #62.5 tx_clk = ~tx_clk;
  assign cts_n = ~cts_on;
  assign dcd_n = ~dcd_on;
  // Bits change after the falling edge, so the rising edge is mid-bit.
  always @(posedge tx_clk) begin
    line_sr <= {txd, line_sr[15:1]};
    if (txd === 1'b0) zeros <= zeros + 1;
  end
endmodule : bstx_line_model

// ### bench/tb_bisync_transmitter.sv
`timescale 1ns/1ps
module tb_bisync_transmitter;
  import bstx_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00, d;
  logic [31:0] pwdata = 32'h0, prdata, exp_q[$], msk_q[$];
  logic pready, pslverr, tx_clk, cts_n, dcd_n, txd, rts_n, irq;
  logic wait_n, ready_n, dtr_n, last_err;
  int stall_cnt = 0, wait_low = 0;
  logic cts_on = 0, dcd_on = 0;
  logic [15:0] line_sr;
  int errors = 0, check_count = 0, zeros;
  always #5 pclk = ~pclk;
  bstx_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_clk(tx_clk),
    .cts_n(cts_n), .dcd_n(dcd_n), .txd(txd), .rts_n(rts_n), .dtr_n(dtr_n),
    .wait_n(wait_n), .ready_n(ready_n), .irq(irq));
  bstx_line_model line (.cts_on(cts_on), .dcd_on(dcd_on), .txd(txd),
    .tx_clk(tx_clk), .cts_n(cts_n), .dcd_n(dcd_n), .line_sr(line_sr),
    .zeros(zeros));
  task automatic end_of_test;
    if (errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] e);
    check_count++;
    if (got !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask : chk
  // Reflected CRC-16 over one character, least significant bit first.
  function automatic logic [15:0] crc_of(input logic [7:0] c);
    logic [15:0] r;
    r = CRC_INIT;
    for (int i = 0; i < 8; i++)
      r = (r >> 1) ^ ((r[0] ^ c[i]) ? CRC_POLY : 16'h0000);
    return r;
  endfunction : crc_of
  // Read results are compared where the completing edge is seen.
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
      chk(prdata & msk_q.pop_front(), exp_q.pop_front());
    if (wait_n === 1'b0) wait_low++;
  end
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] v);
    int n;
    n = 0;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    last_err = pslverr;
    stall_cnt = n;
    psel <= 1'b0; penable <= 1'b0;
    // One idle cycle keeps the next request off this release edge.
    @(posedge pclk);
    if (n >= 3000) begin
      errors++;
      end_of_test();
    end
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    apb(a, 1'b0, 32'h0);
  endtask : rd
  // The control port takes a pointer write before every register write.
  task automatic wreg(input logic [2:0] p, input logic [7:0] v);
    apb(OFS_CTRL, 1'b1, {29'h0, p});
    apb(OFS_CTRL, 1'b1, {24'h0, v});
  endtask : wreg
  task automatic wait_char(input logic [7:0] c);
    int n;
    n = 0;
    while (line_sr[15:8] !== c && n < 60) begin
      @(posedge tx_clk);
      n++;
    end
    chk({24'h0, line_sr[15:8]}, {24'h0, c});
    @(posedge pclk);
  endtask : wait_char
  initial begin
    #200us;
    errors++;
    end_of_test();
  end
  initial begin
    void'($urandom(79679));
    d = 8'($urandom) & 8'h0f;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFS_CTRL, 32'h44, 32'h44);
    rd(8'h3c, 32'h0, 32'hffffffff);
    chk({31'h0, last_err}, 32'h1);
    wreg(PTR_LINE_FMT, 8'h00);
    wreg(PTR_SYNC1, 8'h7e);
    wreg(PTR_RX_CTRL, 8'h20);
    wreg(PTR_TX_CTRL, 8'h0a);
    repeat (30) @(posedge tx_clk);
    chk(zeros, 0);
    chk({31'h0, rts_n}, 32'h0);
    cts_on <= 1'b1;
    wait_char(8'h7e);
    repeat (8) @(posedge tx_clk);
    wait_char(8'h7e);
    wreg(PTR_INT_MODE, 8'h03);
    apb(OFS_CTRL, 1'b1, {26'h0, CMD_RST_EXT, 3'h0});
    apb(OFS_IRQ_CLR, 1'b1, 32'h3);
    apb(OFS_IRQ_EN, 1'b1, 32'h3);
    dcd_on <= 1'b1;
    repeat (10) @(posedge pclk);
    rd(OFS_IRQ_STAT, 32'h2, 32'h2);
    chk({31'h0, irq}, 32'h1);
    rd(OFS_CTRL, 32'h28, 32'h28);
    apb(OFS_IRQ_EN, 1'b1, 32'h0);
    chk({31'h0, irq}, 32'h0);
    apb(OFS_CTRL, 1'b1, {26'h0, CMD_RST_EXT, 3'h0});
    apb(OFS_IRQ_CLR, 1'b1, 32'h3);
    rd(OFS_IRQ_STAT, 32'h0, 32'h2);
    wreg(PTR_TX_CTRL, 8'h0b);
    apb(OFS_TXDATA, 1'b1, {24'h0, d});
    apb(OFS_CTRL, 1'b1, {24'h0, CRC_CMD_EOM, 6'h0});
    rd(OFS_CTRL, 32'h0, 32'h40);
    wait_char(d);
    repeat (16) @(posedge tx_clk);
    chk({16'h0, line_sr}, {16'h0, crc_of(d)});
    repeat (8) @(posedge tx_clk);
    chk({24'h0, line_sr[15:8]}, 32'h7e);
    repeat (16) @(posedge tx_clk);
    @(posedge pclk);
    rd(OFS_CTRL, 32'h40, 32'h40);
    rd(OFS_IRQ_STAT, 32'h3, 32'h3);
    wreg(PTR_VECTOR, 8'hf0);
    wreg(PTR_INT_MODE, 8'h07);
    rd(OFS_VECTOR, 32'hf2, 32'hff);
    wreg(PTR_INT_MODE, 8'hc0);
    chk({31'h0, ready_n}, 32'h0);
    wreg(PTR_INT_MODE, 8'h80);
    apb(OFS_TXDATA, 1'b1, 32'h55);
    apb(OFS_TXDATA, 1'b1, 32'haa);
    // The third write always meets a full buffer and must be held.
    apb(OFS_TXDATA, 1'b1, 32'h33);
    chk({31'h0, stall_cnt > 0 && wait_low > 0}, 32'h1);
    wreg(PTR_TX_CTRL, 8'h00);
    chk({30'h0, rts_n, dtr_n}, 32'h3);
    @(posedge pclk);
    chk({31'h0, txd}, 32'h1);
    end_of_test();
  end
endmodule : tb_bisync_transmitter

// ### design/bstx_crc16.sv
`timescale 1ns/1ps
module bstx_crc16 #(
  parameter logic [15:0] POLY = bstx_pkg::CRC_POLY
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Checksum port
  bstx_crc_if.gen  crc
);
  import bstx_pkg::*;

  logic [15:0] crc_reg;
  logic [15:0] crc_next;
  logic        fb;

  // Bits go out least significant first, so the reflected form is used.
  assign fb       = crc_reg[0] ^ crc.bit_in;
  assign crc_next = (crc_reg >> 1) ^ (fb ? POLY : CRC_INIT);
  assign crc.value = crc_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_reg <= CRC_INIT;
    end else if (crc.clr) begin
      crc_reg <= CRC_INIT;
    end else if (crc.step) begin
      crc_reg <= crc_next;
    end
  end
endmodule : bstx_crc16

// ### design/bstx_sync2.sv
`timescale 1ns/1ps
module bstx_sync2 #(
  parameter int         W         = 1,
  parameter logic [W-1:0] RST_VAL = '1
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Asynchronous level in, synchronised level out
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= RST_VAL;
      q_out    <= RST_VAL;
    end else begin
      meta_reg <= d_in;
      q_out    <= meta_reg;
    end
  end
endmodule : bstx_sync2

// ### design/bstx_top.sv
`timescale 1ns/1ps
module bstx_top #(
  parameter bit          IS_SECOND = 1'b1
) (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial line and modem pins
  input  wire logic        tx_clk,
  input  wire logic        cts_n,
  input  wire logic        dcd_n,
  output logic             txd,
  output logic             rts_n,
  output logic             dtr_n,
  // Transfer pacing and interrupt
  output logic             wait_n,
  output logic             ready_n,
  output logic             irq
);
  import bstx_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [2:0]        ptr_reg;
  logic [7:0]        interrupt_mode_reg, vector_reg, receive_control_reg;
  logic [7:0]        line_format_reg, transmit_control_reg;
  logic [7:0]        first_sync_char_reg, second_sync_char_reg;
  logic [7:0]        buf_reg;
  logic              buf_full_reg, underrun_end_of_message_flag;
  logic              ext_latch_reg, cts_prev_reg, dcd_prev_reg, eom_prev_reg;
  logic [IRQ_W-1:0]  irq_stat_reg, irq_en_reg, irq_stat_next;
  logic [15:0]       shift_reg;
  logic [4:0]        left_reg;
  logic              incl_reg, crc_busy_reg, txd_reg, tbe_prev_reg;
  logic              clk_prev_reg;
  logic [2:0]        pins_s;
  bstx_crc_if        crc ();

  bstx_sync2 #(.W(3), .RST_VAL(3'h7)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d_in    ({tx_clk, cts_n, dcd_n}),
    .q_out   (pins_s)
  );

  bstx_crc16 u_crc (
    .pclk    (pclk),
    .presetn (presetn),
    .crc     (crc.gen)
  );

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  wire acc      = psel & penable;
  wire hit_ctrl = paddr == OFS_CTRL;
  wire hit_txd  = paddr == OFS_TXDATA;
  wire hit_vec  = paddr == OFS_VECTOR;
  wire hit_ist  = paddr == OFS_IRQ_STAT;
  wire hit_icl  = paddr == OFS_IRQ_CLR;
  wire hit_ien  = paddr == OFS_IRQ_EN;
  wire mapped   = hit_ctrl | hit_txd | hit_vec | hit_ist | hit_icl | hit_ien;
  wire wr_mode  = interrupt_mode_reg[IM_WR_EN];
  wire wait_sel = wr_mode & ~interrupt_mode_reg[IM_WR_READY];
  wire rdy_sel  = wr_mode & interrupt_mode_reg[IM_WR_READY];
  // A data write into a full buffer is held in wait mode, else dropped.
  wire stall    = acc & pwrite & hit_txd & buf_full_reg & wait_sel;
  wire drop     = acc & pwrite & hit_txd & buf_full_reg & ~wait_sel;
  wire do_wr    = acc & pwrite & ~stall;
  wire ctrl_wr  = do_wr & hit_ctrl;
  wire cmd_wr   = ctrl_wr & (ptr_reg == PTR_CMD);
  wire reg_wr   = ctrl_wr & (ptr_reg != PTR_CMD);
  wire [2:0] cmd     = pwdata[CMD_LSB +: 3];
  wire [1:0] crc_cmd = pwdata[CRC_CMD_LSB +: 2];
  wire chan_rst = cmd_wr & (cmd == CMD_CHAN_RST);
  wire ext_clr  = cmd_wr & (cmd == CMD_RST_EXT);
  wire txip_clr = cmd_wr & (cmd == CMD_RST_TXIP);
  wire eom_clr  = cmd_wr & (crc_cmd == CRC_CMD_EOM);
  wire gen_clr  = cmd_wr & (crc_cmd == CRC_CMD_GEN);
  wire data_wr  = do_wr & hit_txd & ~buf_full_reg;

  assign pready  = ~stall;
  assign pslverr = acc & pready & (~mapped | drop);
  assign wait_n  = ~stall;
  assign ready_n = ~(rdy_sel & ~buf_full_reg &
                     transmit_control_reg[TC_TX_EN]);

  // ----------------------------------------------------------------------
  // Line and status decode
  // ----------------------------------------------------------------------
  wire cts_act  = ~pins_s[1];
  wire dcd_act  = ~pins_s[0];
  wire tick     = clk_prev_reg & ~pins_s[2];
  wire tx_en    = transmit_control_reg[TC_TX_EN];
  wire auto_en  = receive_control_reg[RC_AUTO];
  wire x1_mode  = line_format_reg[LF_CLK_LSB +: 2] == CLK_X1;
  wire tx_go    = tx_en & x1_mode & (~auto_en | cts_act);
  wire load     = tick & tx_go & (left_reg == 5'd0);
  wire tbe      = ~buf_full_reg & ~crc_busy_reg;
  wire tbe_rise = tbe & ~tbe_prev_reg;
  wire ext_chg  = (cts_act != cts_prev_reg) | (dcd_act != dcd_prev_reg) |
                  (underrun_end_of_message_flag != eom_prev_reg);
  wire ext_set  = ext_chg & interrupt_mode_reg[IM_EXT_EN];

  // Character choice: data first, then CRC once, then fill syncs.
  bstx_kind_t kind;
  assign kind = buf_full_reg ? BSTX_DATA :
                (~underrun_end_of_message_flag ? BSTX_CRC :
                 BSTX_SYNC);

  wire par_en   = line_format_reg[LF_PAR_EN];
  wire par_bit  = line_format_reg[LF_PAR_EVEN] ? ^buf_reg : ~^buf_reg;
  wire sync16   = line_format_reg[LF_SYNC_LSB +: 2] == SYNC_16;
  wire [15:0] data_word = par_en ? {7'h00, par_bit, buf_reg}
                                 : {8'h00, buf_reg};
  wire [15:0] sync_word = sync16 ? {second_sync_char_reg, first_sync_char_reg}
                                 : {8'h00, first_sync_char_reg};
  wire [4:0]  data_len  = par_en ? LEN_PAR : LEN_DATA;
  wire [4:0]  sync_len  = sync16 ? LEN_WORD : LEN_DATA;
  wire [15:0] char_word = (kind == BSTX_DATA) ? data_word :
                          (kind == BSTX_CRC) ? crc.value : sync_word;
  wire [4:0]  char_len  = (kind == BSTX_DATA) ? data_len :
                          (kind == BSTX_CRC) ? LEN_WORD : sync_len;
  // The enable is sampled as the character enters the shifter.
  wire incl_new = (kind == BSTX_DATA) &
                  transmit_control_reg[TC_CRC_EN];
  wire shifting = tick & tx_en & (left_reg != 5'd0);

  assign crc.clr    = chan_rst | gen_clr | (load & (kind == BSTX_CRC));
  assign crc.step   = (load & incl_new) | (shifting & incl_reg);
  assign crc.bit_in = load ? char_word[0] : shift_reg[0];

  // ----------------------------------------------------------------------
  // Register file behind the pointer
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_reg              <= PTR_CMD;
      interrupt_mode_reg   <= 8'h00;
      vector_reg           <= 8'h00;
      receive_control_reg  <= 8'h00;
      line_format_reg      <= 8'h00;
      transmit_control_reg <= 8'h00;
      first_sync_char_reg  <= 8'h00;
      second_sync_char_reg <= 8'h00;
    end else if (chan_rst) begin
      ptr_reg              <= PTR_CMD;
      interrupt_mode_reg   <= 8'h00;
      receive_control_reg  <= 8'h00;
      line_format_reg      <= 8'h00;
      transmit_control_reg <= 8'h00;
    end else if (cmd_wr) begin
      ptr_reg <= pwdata[2:0];
    end else if (reg_wr) begin
      ptr_reg <= PTR_CMD;
      unique case (ptr_reg)
        PTR_INT_MODE: interrupt_mode_reg   <= pwdata[7:0];
        PTR_VECTOR:   vector_reg           <= pwdata[7:0];
        PTR_RX_CTRL:  receive_control_reg  <= pwdata[7:0];
        PTR_LINE_FMT: line_format_reg      <= pwdata[7:0];
        PTR_TX_CTRL:  transmit_control_reg <= pwdata[7:0];
        PTR_SYNC1:    first_sync_char_reg  <= pwdata[7:0];
        PTR_SYNC2:    second_sync_char_reg <= pwdata[7:0];
        default:      ptr_reg              <= PTR_CMD;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Buffer, underrun flag and status latches
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_reg                      <= 8'h00;
      buf_full_reg                 <= 1'b0;
      underrun_end_of_message_flag <= 1'b1;
      ext_latch_reg                <= 1'b0;
    end else if (chan_rst) begin
      buf_full_reg                 <= 1'b0;
      underrun_end_of_message_flag <= 1'b1;
      ext_latch_reg                <= 1'b0;
    end else begin
      if (data_wr) begin
        buf_reg      <= pwdata[7:0];
        buf_full_reg <= 1'b1;
      end else if (load && kind == BSTX_DATA) begin
        buf_full_reg <= 1'b0;
      end
      // Loading the CRC sets the flag again, so it is sent only once.
      if (load && kind == BSTX_CRC) begin
        underrun_end_of_message_flag <= 1'b1;
      end else if (eom_clr) begin
        underrun_end_of_message_flag <= 1'b0;
      end
      ext_latch_reg <= ext_set | (ext_latch_reg & ~ext_clr);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cts_prev_reg <= 1'b0;
      dcd_prev_reg <= 1'b0;
      eom_prev_reg <= 1'b1;
      tbe_prev_reg <= 1'b1;
      clk_prev_reg <= 1'b1;
      irq_stat_reg <= '0;
      irq_en_reg   <= '0;
    end else begin
      cts_prev_reg <= cts_act;
      dcd_prev_reg <= dcd_act;
      eom_prev_reg <= underrun_end_of_message_flag;
      tbe_prev_reg <= tbe;
      clk_prev_reg <= pins_s[2];
      irq_stat_reg <= irq_stat_next;
      if (do_wr && hit_ien) begin
        irq_en_reg <= pwdata[IRQ_W-1:0];
      end
    end
  end

  // Set wins over any clear arriving in the same cycle.
  wire [IRQ_W-1:0] irq_set = {ext_set,
                              tbe_rise & interrupt_mode_reg[IM_TX_IE]};
  wire [IRQ_W-1:0] irq_clr = ((do_wr & hit_icl) ? pwdata[IRQ_W-1:0] : '0) |
                             {ext_clr | chan_rst, txip_clr | chan_rst};
  assign irq_stat_next = irq_set | (irq_stat_reg & ~irq_clr);
  assign irq = |(irq_stat_reg & irq_en_reg);

  // ----------------------------------------------------------------------
  // Serial shifter, one bit per falling link clock edge
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_reg    <= 16'h0000;
      left_reg     <= 5'd0;
      incl_reg     <= 1'b0;
      crc_busy_reg <= 1'b0;
      txd_reg      <= 1'b1;
    end else if (chan_rst || !tx_en) begin
      // Disabled: the line marks, or spaces while break is asked for.
      left_reg     <= 5'd0;
      crc_busy_reg <= 1'b0;
      txd_reg      <= ~transmit_control_reg[TC_BREAK];
    end else if (load) begin
      txd_reg      <= char_word[0];
      shift_reg    <= char_word >> 1;
      left_reg     <= char_len - 5'd1;
      incl_reg     <= incl_new;
      crc_busy_reg <= kind == BSTX_CRC;
    end else if (shifting) begin
      txd_reg   <= shift_reg[0];
      shift_reg <= shift_reg >> 1;
      left_reg  <= left_reg - 5'd1;
    end
  end

  assign txd   = txd_reg;
  assign rts_n = ~transmit_control_reg[TC_RTS];
  assign dtr_n = ~transmit_control_reg[TC_DTR];

  // ----------------------------------------------------------------------
  // Read side
  // ----------------------------------------------------------------------
  wire [2:0] cause = irq_stat_reg[IRQ_EXT] ? VEC_EXT :
                     (irq_stat_reg[IRQ_TBE] ? VEC_TBE : VEC_NONE);
  wire       sav   = IS_SECOND & interrupt_mode_reg[IM_SAV];
  wire [7:0] vec_rd = sav ? {vector_reg[7:4], cause, vector_reg[0]}
                          : vector_reg;
  wire [7:0] status = {1'b0, underrun_end_of_message_flag, cts_act, 1'b0,
                       dcd_act, tbe, irq, 1'b0};
  assign prdata = (!acc || pwrite) ? 32'h0000_0000 :
                  hit_ctrl ? {24'h000000, status} :
                  hit_vec  ? {24'h000000, vec_rd} :
                  hit_ist  ? {30'h0, irq_stat_reg} :
                  hit_ien  ? {30'h0, irq_en_reg} : 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_cts_hold_off: assert property (load |-> (!auto_en || cts_act))
    else $error("character started without CTS under auto enables");
  a_ext_event_raise: assert property (
    ext_set && !ext_clr && !chan_rst |=>
    ext_latch_reg && irq_stat_reg[IRQ_EXT])
    else $error("status change did not raise external event");
  a_tbe_irq: assert property (
    tbe_rise && interrupt_mode_reg[IM_TX_IE] |=> irq_stat_reg[IRQ_TBE])
    else $error("buffer empty did not raise transmit interrupt");
  a_wait_stall: assert property (stall |-> !pready && !wait_n)
    else $error("wait mode did not stall full buffer write");
  a_ready_pace: assert property (rdy_sel && tx_en && !buf_full_reg
    |-> !ready_n) else $error("ready not offered on empty buffer");
  a_eom_crc_send: assert property (load && kind == BSTX_CRC |=>
    underrun_end_of_message_flag && crc_busy_reg && left_reg == 5'd15)
    else $error("CRC load did not set the flag and 16 bits");
  a_vector_plain: assert property (!sav |-> vec_rd == vector_reg)
    else $error("vector modified outside second channel");
  a_ptr_write: assert property (cmd_wr && !chan_rst |=>
    ptr_reg == $past(pwdata[2:0])) else $error("pointer not loaded");
  a_ptr_return: assert property (reg_wr |=> ptr_reg == PTR_CMD)
    else $error("pointer did not return to command");
  a_crc_exclude: assert property (
    shifting && !incl_reg |-> !crc.step)
    else $error("excluded character stepped the CRC");
  a_par_length: assert property (load && kind == BSTX_DATA && par_en
    |=> left_reg == 5'd8) else $error("parity bit not framed");
  a_reset_flag: assert property (chan_rst |=>
    underrun_end_of_message_flag) else $error("flag clear after reset");
  a_sync_fill: assert property (load && !buf_full_reg &&
    underrun_end_of_message_flag |=> !crc_busy_reg && !incl_reg)
    else $error("fill sync not sent or entered CRC");
  a_ext_latch_hold: assert property (ext_latch_reg && !ext_clr &&
    !chan_rst |=> ext_latch_reg) else $error("external event lost");

  c_crc_sent:  cover property (load && kind == BSTX_CRC);
  c_sync_fill: cover property (load && kind == BSTX_SYNC);
  c_wait_hit:  cover property (stall ##1 !stall);
  c_ext_irq:   cover property (ext_set ##[1:20] ext_clr);
endmodule : bstx_top

// ### include/bstx_crc_if.sv
`timescale 1ns/1ps
interface bstx_crc_if;
  logic        clr;
  logic        step;
  logic        bit_in;
  logic [15:0] value;
  modport gen  (input clr, input step, input bit_in, output value);
  modport user (output clr, output step, output bit_in, input value);
endinterface : bstx_crc_if

// ### include/bstx_pkg.sv
package bstx_pkg;
  // ----------------------------------------------------------------------
  // Register map, byte addresses on the APB bus
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_TXDATA   = 8'h04;
  localparam logic [7:0] OFS_VECTOR   = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFS_IRQ_CLR  = 8'h10;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h14;
  // ----------------------------------------------------------------------
  // Pointer values and commands carried by the control port
  // ----------------------------------------------------------------------
  localparam logic [2:0] PTR_CMD      = 3'h0;
  localparam logic [2:0] PTR_INT_MODE = 3'h1;
  localparam logic [2:0] PTR_VECTOR   = 3'h2;
  localparam logic [2:0] PTR_RX_CTRL  = 3'h3;
  localparam logic [2:0] PTR_LINE_FMT = 3'h4;
  localparam logic [2:0] PTR_TX_CTRL  = 3'h5;
  localparam logic [2:0] PTR_SYNC1    = 3'h6;
  localparam logic [2:0] PTR_SYNC2    = 3'h7;
  localparam int         CMD_LSB      = 3;
  localparam logic [2:0] CMD_RST_EXT  = 3'h2;
  localparam logic [2:0] CMD_CHAN_RST = 3'h3;
  localparam logic [2:0] CMD_RST_TXIP = 3'h5;
  localparam int         CRC_CMD_LSB  = 6;
  localparam logic [1:0] CRC_CMD_GEN  = 2'h1;
  localparam logic [1:0] CRC_CMD_EOM  = 2'h3;
  // ----------------------------------------------------------------------
  // Field positions inside the write registers
  // ----------------------------------------------------------------------
  localparam int         IM_EXT_EN    = 0;
  localparam int         IM_TX_IE     = 1;
  localparam int         IM_SAV       = 2;
  localparam int         IM_WR_READY  = 6;
  localparam int         IM_WR_EN     = 7;
  localparam int         RC_AUTO      = 5;
  localparam int         LF_PAR_EN    = 0;
  localparam int         LF_PAR_EVEN  = 1;
  localparam int         LF_SYNC_LSB  = 4;
  localparam int         LF_CLK_LSB   = 6;
  localparam logic [1:0] SYNC_16      = 2'h1;
  localparam logic [1:0] CLK_X1       = 2'h0;
  localparam int         TC_CRC_EN    = 0;
  localparam int         TC_RTS       = 1;
  localparam int         TC_TX_EN     = 3;
  localparam int         TC_BREAK     = 4;
  localparam int         TC_DTR       = 7;
  // ----------------------------------------------------------------------
  // Status, interrupt and vector layout
  // ----------------------------------------------------------------------
  localparam int         ST_INT       = 1;
  localparam int         ST_TBE       = 2;
  localparam int         ST_DCD       = 3;
  localparam int         ST_CTS       = 5;
  localparam int         ST_EOM       = 6;
  localparam int         IRQ_TBE      = 0;
  localparam int         IRQ_EXT      = 1;
  localparam int         IRQ_W        = 2;
  localparam int         VEC_LSB      = 1;
  localparam logic [2:0] VEC_TBE      = 3'h0;
  localparam logic [2:0] VEC_EXT      = 3'h1;
  localparam logic [2:0] VEC_NONE     = 3'h3;
  // ----------------------------------------------------------------------
  // Character framing and checksum
  // ----------------------------------------------------------------------
  localparam logic [4:0]  LEN_DATA    = 5'd8;
  localparam logic [4:0]  LEN_PAR     = 5'd9;
  localparam logic [4:0]  LEN_WORD    = 5'd16;
  localparam logic [15:0] CRC_POLY    = 16'ha001;
  localparam logic [15:0] CRC_INIT    = 16'h0000;
  typedef enum logic [1:0] {BSTX_DATA, BSTX_CRC, BSTX_SYNC} bstx_kind_t;
endpackage : bstx_pkg
